// >>> hw/lto_decoder.sv
// Behaviour
// - port rewritten from itself uses pin levels, not output latch, as operand.
// - write to timer zero count with dest set clears assigned prescaler.
// - instruction pointer change or true test costs two cycles, second a no-op.
// - lone second word of two-word instruction executes as no-op.
// - literal_add adds literal to working register, updates all five arithmetic flags.
// - literal_and ANDs literal into working register, updates Z and N.
// - literal_inclusive_or ORs literal into working register, updates Z and N.
// - literal_exclusive_or XORs literal into working register, updates Z and N.
// - pointer_literal_load, two words, loads 12-bit value into selected file_pointer.
// - literal_load_bank puts 4-bit literal into bank_select_register bits 3..0.
// - literal_load_w loads literal into working register, flags unchanged.
// - literal_multiply multiplies literal by working register, flags unchanged.
// - return_with_literal returns, loads literal into working register, two cycles.
// - literal_minus_w puts literal minus working register there, updates all flags.
// - table_read_op is two cycles, low two bits choose pointer update.
// - table_write_op is two cycles, low two bits choose pointer update.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module lto_decoder import lto_pkg::*; #(
   parameter int          PC_W           = 21,
   parameter int          TP_W           = 21,
   parameter logic [11:0] IO_PORT2_ADDR  = 12'h0F1,
   parameter logic [11:0] TIMER0_ADDR    = 12'h0F6
) (
   // clock and reset
   input  wire logic            pclk,
   input  wire logic            presetn,
   // apb slave
   input  wire logic [7:0]      paddr,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [31:0]     pwdata,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   // program memory fetch
   output logic [PC_W-1:0]      fetch_addr,
   input  wire logic [15:0]     fetch_word,
   // return stack
   input  wire logic [PC_W-1:0] ret_addr,
   output logic                 ret_pop,
   // table access
   output logic [TP_W-1:0]      tbl_addr,
   output logic                 tbl_rd_en,
   input  wire logic [7:0]      tbl_rd_data,
   output logic                 tbl_wr_en,
   output logic [7:0]           tbl_wr_data,
   // file read-modify-write helper
   input  wire logic            rmw_valid,
   input  wire logic [11:0]     rmw_addr,
   input  wire logic            rmw_dest,
   input  wire logic [7:0]      file_rd_data,
   input  wire logic [7:0]      port_pins,
   input  wire logic            prescaler_assigned,
   output logic                 rmw_operand_valid,
   output logic [7:0]           rmw_operand,
   output logic                 prescaler_clear
);
   lto_state_t        state_reg;
   logic [1:0]        q_reg;
   logic              run_reg;
   logic [15:0]       ir_reg;
   logic [7:0]        word2_reg, lit_reg, res_reg;
   logic [15:0]       prod_res_reg;
   logic [4:0]        flg_res_reg, flg_mask_reg;
   logic [PC_W-1:0]   pc_reg;
   logic [7:0]        work_reg;
   logic [4:0]        status_reg;
   logic [3:0]        bank_reg;
   logic [11:0]       fptr_reg [3];
   logic [15:0]       prod_reg;
   logic [TP_W-1:0]   tblptr_reg;
   logic [7:0]        tbllat_reg;
   logic              tbl_rd_pend_reg;
   logic [31:0]       rd_mux;
   logic              rd_hit;
   logic              apb_wr;
   logic              q1, q2, q3, q4;
   logic              is_lit_alu;
   logic              is_ldbank, is_ptrld, is_ret, is_tabrd, is_tabwr;
   lto_alu_op_t       alu_op;
   logic [7:0]        alu_res;
   logic [15:0]       alu_prod;
   logic [4:0]        alu_flags, alu_mask;
   logic [TP_W-1:0]   tp_access, tp_next;

   assign fetch_addr = pc_reg;
   assign apb_wr     = psel && penable && pwrite && pready;
   assign q1         = run_reg && (q_reg == 2'd0);
   assign q2         = run_reg && (q_reg == 2'd1);
   assign q3         = run_reg && (q_reg == 2'd2);
   assign q4         = run_reg && (q_reg == 2'd3);

   // decode
   always_comb begin
      is_ldbank  = (ir_reg[15:4] == OPC_LDBANK);
      is_ptrld   = (ir_reg[15:6] == OPC_PTRLD);
      is_ret     = (ir_reg[15:8] == OPC_RET);
      is_tabrd   = (ir_reg[15:2] == OPC_TABRD);
      is_tabwr   = (ir_reg[15:2] == OPC_TABWR);
      is_lit_alu = 1'b1;
      alu_op     = ALU_MOV;
      unique case (ir_reg[15:8])
         OPC_ADD: alu_op = ALU_ADD;
         OPC_AND: alu_op = ALU_AND;
         OPC_IOR: alu_op = ALU_IOR;
         OPC_XOR: alu_op = ALU_XOR;
         OPC_SUB: alu_op = ALU_SUB;
         OPC_MOV: alu_op = ALU_MOV;
         OPC_MUL: alu_op = ALU_MUL;
         default: is_lit_alu = 1'b0;
      endcase
   end

   lto_lit_alu u_alu (
      .op        (alu_op),
      .w_val     (work_reg),
      .k_val     (lit_reg),
      .result    (alu_res),
      .product   (alu_prod),
      .flags_out (alu_flags),
      .flag_mask (alu_mask)
   );

   lto_tbl_ptr #(.W(TP_W)) u_tptr (
      .ptr         (tblptr_reg),
      .mode        (ir_reg[1:0]),
      .access_addr (tp_access),
      .ptr_next    (tp_next)
   );

   // instruction phase counter, stops while software holds the core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_reg <= 2'd0;
      end else if (run_reg) begin
         q_reg <= q_reg + 2'd1;
      end
   end

   // fetch, literal read and process phases
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ir_reg       <= OPC_NOP;
         word2_reg    <= 8'h00;
         lit_reg      <= 8'h00;
         res_reg      <= 8'h00;
         prod_res_reg <= 16'h0000;
         flg_res_reg  <= 5'h00;
         flg_mask_reg <= 5'h00;
      end else begin
         if (q1) begin
            if (state_reg == ST_EXEC) begin
               ir_reg <= fetch_word;
            end else if (state_reg == ST_WORD2) begin
               word2_reg <= fetch_word[7:0];
            end
         end
         if (q2) begin
            lit_reg <= ir_reg[7:0];
         end
         if (q3) begin
            res_reg      <= alu_res;
            prod_res_reg <= alu_prod;
            flg_res_reg  <= alu_flags;
            flg_mask_reg <= alu_mask;
         end
      end
   end

   // write phase: sequencing and instruction pointer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_EXEC;
         pc_reg    <= '0;
         ret_pop   <= 1'b0;
      end else begin
         ret_pop <= 1'b0;
         if (q4) begin
            unique case (state_reg)
               ST_EXEC: begin
                  if (is_ret) begin
                     pc_reg    <= ret_addr;
                     ret_pop   <= 1'b1;
                     state_reg <= ST_NOP2;
                  end else if (is_tabrd || is_tabwr) begin
                     pc_reg    <= pc_reg + PC_W'(1);
                     state_reg <= ST_NOP2;
                  end else if (is_ptrld) begin
                     pc_reg    <= pc_reg + PC_W'(1);
                     state_reg <= ST_WORD2;
                  end else begin
                     // a lone second word decodes as nothing here
                     pc_reg    <= pc_reg + PC_W'(1);
                  end
               end
               ST_WORD2: begin
                  pc_reg    <= pc_reg + PC_W'(1);
                  state_reg <= ST_EXEC;
               end
               ST_NOP2: state_reg <= ST_EXEC;
            endcase
         end
      end
   end

   // working register, flags, bank, pointers; apb write wins over the core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         work_reg    <= RST_WORK;
         status_reg  <= RST_STATUS;
         bank_reg    <= RST_BANK;
         fptr_reg[0] <= RST_FPTR;
         fptr_reg[1] <= RST_FPTR;
         fptr_reg[2] <= RST_FPTR;
         prod_reg    <= 16'h0000;
         run_reg     <= RST_RUN;
      end else begin
         if (q4 && state_reg == ST_EXEC) begin
            if (is_lit_alu && alu_op == ALU_MUL) begin
               prod_reg <= prod_res_reg;
            end else if (is_lit_alu) begin
               work_reg   <= res_reg;
               status_reg <= (status_reg & ~flg_mask_reg) | (flg_res_reg & flg_mask_reg);
            end else if (is_ret) begin
               work_reg <= lit_reg;
            end else if (is_ldbank) begin
               bank_reg <= ir_reg[3:0];
            end
         end
         if (q4 && state_reg == ST_WORD2 && ir_reg[5:4] != 2'b11) begin
            fptr_reg[ir_reg[5:4]] <= {ir_reg[3:0], word2_reg};
         end
         if (apb_wr) begin
            unique case (paddr)
               OFS_WORK:   work_reg    <= pwdata[7:0];
               OFS_STATUS: status_reg  <= pwdata[4:0];
               OFS_BANK:   bank_reg    <= pwdata[3:0];
               OFS_FPTR0:  fptr_reg[0] <= pwdata[11:0];
               OFS_FPTR1:  fptr_reg[1] <= pwdata[11:0];
               OFS_FPTR2:  fptr_reg[2] <= pwdata[11:0];
               OFS_CTRL:   run_reg     <= pwdata[0];
               default: ;
            endcase
         end
      end
   end

   // table pointer, latch and program memory strobes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tblptr_reg      <= '0;
         tbllat_reg      <= 8'h00;
         tbl_rd_pend_reg <= 1'b0;
         tbl_addr        <= '0;
         tbl_rd_en       <= 1'b0;
         tbl_wr_en       <= 1'b0;
         tbl_wr_data     <= 8'h00;
      end else begin
         tbl_rd_en <= 1'b0;
         tbl_wr_en <= 1'b0;
         if (q4 && state_reg == ST_EXEC && (is_tabrd || is_tabwr)) begin
            tblptr_reg      <= tp_next;
            tbl_addr        <= tp_access;
            tbl_rd_en       <= is_tabrd;
            tbl_wr_en       <= is_tabwr;
            tbl_wr_data     <= tbllat_reg;
            tbl_rd_pend_reg <= is_tabrd;
         end
         // read data is taken at the end of the no-op second cycle
         if (q4 && state_reg == ST_NOP2 && tbl_rd_pend_reg) begin
            tbllat_reg      <= tbl_rd_data;
            tbl_rd_pend_reg <= 1'b0;
         end
         if (apb_wr && paddr == OFS_TBLPTR) begin
            tblptr_reg <= pwdata[TP_W-1:0];
         end
         if (apb_wr && paddr == OFS_TBLLAT) begin
            tbllat_reg <= pwdata[7:0];
         end
      end
   end

   // operand fetch for file rewrite and timer prescaler clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rmw_operand_valid <= 1'b0;
         rmw_operand       <= 8'h00;
         prescaler_clear   <= 1'b0;
      end else begin
         rmw_operand_valid <= rmw_valid;
         if (rmw_valid) begin
            // latch may hold 1 where an outside driver pulls the pin low
            rmw_operand <= (rmw_addr == IO_PORT2_ADDR) ? port_pins : file_rd_data;
         end
         prescaler_clear <= rmw_valid && rmw_dest && (rmw_addr == TIMER0_ADDR)
                            && prescaler_assigned;
      end
   end

   // apb read mux
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (paddr)
         OFS_WORK:   rd_mux[7:0]      = work_reg;
         OFS_STATUS: rd_mux[4:0]      = status_reg;
         OFS_BANK:   rd_mux[3:0]      = bank_reg;
         OFS_FPTR0:  rd_mux[11:0]     = fptr_reg[0];
         OFS_FPTR1:  rd_mux[11:0]     = fptr_reg[1];
         OFS_FPTR2:  rd_mux[11:0]     = fptr_reg[2];
         OFS_PROD:   rd_mux[15:0]     = prod_reg;
         OFS_TBLPTR: rd_mux[TP_W-1:0] = tblptr_reg;
         OFS_TBLLAT: rd_mux[7:0]      = tbllat_reg;
         OFS_CTRL:   rd_mux[0]        = run_reg;
         OFS_IPTR:   rd_mux[PC_W-1:0] = pc_reg;
         default:    rd_hit           = 1'b0;
      endcase
   end

   // one wait state so read data leaves a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !rd_hit;
         if (psel && penable && !pready && !pwrite) begin
            prdata <= rd_mux;
         end
      end
   end
endmodule

// >>> hw/lto_lit_alu.sv
`timescale 1ns/1ps
module lto_lit_alu import lto_pkg::*; (
   // operation and operands
   input  wire lto_alu_op_t op,
   input  wire logic [7:0]  w_val,
   input  wire logic [7:0]  k_val,
   // results
   output logic [7:0]       result,
   output logic [15:0]      product,
   output logic [4:0]       flags_out,
   output logic [4:0]       flag_mask
);
   logic [8:0] sum9;
   logic [4:0] half5;

   always_comb begin
      sum9      = 9'h000;
      half5     = 5'h00;
      result    = w_val;
      flags_out = 5'h00;
      flag_mask = FLG_NONE;
      product   = w_val * k_val;
      unique case (op)
         ALU_ADD: begin
            sum9      = {1'b0, w_val} + {1'b0, k_val};
            half5     = {1'b0, w_val[3:0]} + {1'b0, k_val[3:0]};
            result    = sum9[7:0];
            flag_mask = FLG_ARITH;
            flags_out[FLG_C]  = sum9[8];
            flags_out[FLG_HC] = half5[4];
            flags_out[FLG_SW] = (w_val[7] == k_val[7]) && (sum9[7] != w_val[7]);
         end
         ALU_SUB: begin
            // borrow is inverted carry: c set means no borrow
            sum9      = {1'b0, k_val} + {1'b0, ~w_val} + 9'h001;
            half5     = {1'b0, k_val[3:0]} + {1'b0, ~w_val[3:0]} + 5'h01;
            result    = sum9[7:0];
            flag_mask = FLG_ARITH;
            flags_out[FLG_C]  = sum9[8];
            flags_out[FLG_HC] = half5[4];
            flags_out[FLG_SW] = (k_val[7] != w_val[7]) && (sum9[7] != k_val[7]);
         end
         ALU_AND: begin
            result    = w_val & k_val;
            flag_mask = FLG_LOGIC;
         end
         ALU_IOR: begin
            result    = w_val | k_val;
            flag_mask = FLG_LOGIC;
         end
         ALU_XOR: begin
            result    = w_val ^ k_val;
            flag_mask = FLG_LOGIC;
         end
         ALU_MOV: result = k_val;
         ALU_MUL: result = w_val;
      endcase
      flags_out[FLG_Z] = (result == 8'h00);
      flags_out[FLG_N] = result[7];
   end
endmodule

// >>> hw/lto_pkg.sv
package lto_pkg;

   // instruction clock phases per instruction cycle
   localparam int        Q_PHASES       = 4;

   // opcode fields, upper bits of the instruction word
   localparam logic [7:0]  OPC_ADD       = 8'h0F;
   localparam logic [7:0]  OPC_AND       = 8'h0B;
   localparam logic [7:0]  OPC_IOR       = 8'h09;
   localparam logic [7:0]  OPC_XOR       = 8'h0A;
   localparam logic [7:0]  OPC_MOV       = 8'h0E;
   localparam logic [7:0]  OPC_MUL       = 8'h0D;
   localparam logic [7:0]  OPC_RET       = 8'h0C;
   localparam logic [7:0]  OPC_SUB       = 8'h08;
   localparam logic [11:0] OPC_LDBANK    = 12'h010;
   localparam logic [9:0]  OPC_PTRLD     = 10'h3B8;
   localparam logic [7:0]  OPC_PTRLD_W2  = 8'hF0;
   localparam logic [13:0] OPC_TABRD     = 14'h0002;
   localparam logic [13:0] OPC_TABWR     = 14'h0003;
   localparam logic [3:0]  OPC_SECOND    = 4'hF;
   localparam logic [15:0] OPC_NOP       = 16'h0000;

   // pointer update modes of table access
   localparam logic [1:0]  TBL_NONE      = 2'h0;
   localparam logic [1:0]  TBL_POSTINC   = 2'h1;
   localparam logic [1:0]  TBL_POSTDEC   = 2'h2;
   localparam logic [1:0]  TBL_PREINC    = 2'h3;

   // status flag positions
   localparam int          FLG_C         = 0;
   localparam int          FLG_HC        = 1;
   localparam int          FLG_Z         = 2;
   localparam int          FLG_SW        = 3;
   localparam int          FLG_N         = 4;
   localparam logic [4:0]  FLG_ARITH     = 5'h1F;
   localparam logic [4:0]  FLG_LOGIC     = 5'h14;
   localparam logic [4:0]  FLG_NONE      = 5'h00;

   // register offsets (byte addresses)
   localparam logic [7:0]  OFS_WORK      = 8'h00;
   localparam logic [7:0]  OFS_STATUS    = 8'h04;
   localparam logic [7:0]  OFS_BANK      = 8'h08;
   localparam logic [7:0]  OFS_FPTR0     = 8'h0C;
   localparam logic [7:0]  OFS_FPTR1     = 8'h10;
   localparam logic [7:0]  OFS_FPTR2     = 8'h14;
   localparam logic [7:0]  OFS_PROD      = 8'h18;
   localparam logic [7:0]  OFS_TBLPTR    = 8'h1C;
   localparam logic [7:0]  OFS_TBLLAT    = 8'h20;
   localparam logic [7:0]  OFS_CTRL      = 8'h24;
   localparam logic [7:0]  OFS_IPTR      = 8'h28;

   // reset values
   localparam logic [7:0]  RST_WORK      = 8'h00;
   localparam logic [4:0]  RST_STATUS    = 5'h00;
   localparam logic [3:0]  RST_BANK      = 4'h0;
   localparam logic [11:0] RST_FPTR      = 12'h000;
   localparam logic        RST_RUN       = 1'b0;

   typedef enum logic [2:0] {
      ALU_ADD, ALU_AND, ALU_IOR, ALU_XOR, ALU_SUB, ALU_MOV, ALU_MUL
   } lto_alu_op_t;

   typedef enum logic [1:0] {ST_EXEC, ST_WORD2, ST_NOP2} lto_state_t;

endpackage

// >>> hw/lto_tbl_ptr.sv
`timescale 1ns/1ps
module lto_tbl_ptr import lto_pkg::*; #(
   parameter int W = 21
) (
   // current pointer and update mode
   input  wire logic [W-1:0] ptr,
   input  wire logic [1:0]   mode,
   // address used and pointer afterwards
   output logic [W-1:0]      access_addr,
   output logic [W-1:0]      ptr_next
);
   always_comb begin
      access_addr = ptr;
      ptr_next    = ptr;
      unique case (mode)
         TBL_NONE:    ptr_next = ptr;
         TBL_POSTINC: ptr_next = ptr + W'(1);
         TBL_POSTDEC: ptr_next = ptr - W'(1);
         TBL_PREINC: begin
            access_addr = ptr + W'(1);
            ptr_next    = ptr + W'(1);
         end
      endcase
   end
endmodule

// >>> tb/lto_decoder_checker.sv
`timescale 1ns/1ps
module lto_decoder_checker import lto_pkg::*; #(
   parameter int          PC_W          = 21,
   parameter logic [11:0] IO_PORT2_ADDR = 12'h0F1,
   parameter logic [11:0] TIMER0_ADDR   = 12'h0F6
) (
   // clock and reset
   input wire logic            pclk,
   input wire logic            presetn,
   // apb handshake
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pready,
   input wire logic            pslverr,
   // core side
   input wire logic [PC_W-1:0] fetch_addr,
   input wire logic [PC_W-1:0] ret_addr,
   input wire logic            ret_pop,
   input wire logic            tbl_rd_en,
   input wire logic            tbl_wr_en,
   // read-modify-write helper
   input wire logic            rmw_valid,
   input wire logic [11:0]     rmw_addr,
   input wire logic            rmw_dest,
   input wire logic [7:0]      file_rd_data,
   input wire logic [7:0]      port_pins,
   input wire logic            prescaler_assigned,
   input wire logic            rmw_operand_valid,
   input wire logic [7:0]      rmw_operand,
   input wire logic            prescaler_clear
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic clr_cause;
   assign clr_cause = rmw_valid && rmw_dest && rmw_addr == TIMER0_ADDR && prescaler_assigned;
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   a_apb_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
      else $error("apb answer not after one wait state");
   a_apb_err: assert property (pslverr |-> pready)
      else $error("slave error without ready");
   a_rmw_answer: assert property (rmw_valid |=> rmw_operand_valid)
      else $error("rmw operand not answered");
   a_port_pins: assert property (rmw_valid && rmw_addr == IO_PORT2_ADDR
      |=> rmw_operand == $past(port_pins)) else $error("port operand not from pins");
   a_file_operand: assert property (rmw_valid && rmw_addr != IO_PORT2_ADDR
      |=> rmw_operand == $past(file_rd_data)) else $error("file operand wrong");
   a_presc_clear: assert property (clr_cause |=> prescaler_clear)
      else $error("prescaler not cleared");
   a_presc_hold: assert property (!clr_cause |=> !prescaler_clear)
      else $error("prescaler cleared without cause");
   a_ret_jump: assert property (ret_pop |-> fetch_addr == $past(ret_addr))
      else $error("return did not load fetch address");
   a_ret_nop: assert property (ret_pop |=> $stable(fetch_addr)[*4])
      else $error("second return cycle not idle");
   a_tbl_pulse: assert property (tbl_rd_en |=> !tbl_rd_en)
      else $error("table read strobe too long");
   a_tbl_excl: assert property (!(tbl_rd_en && tbl_wr_en))
      else $error("table read and write together");
endmodule

// >>> tb/lto_decoder_tb.sv
`timescale 1ns/1ps
module lto_decoder_tb import lto_pkg::*;;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr, ret_pop;
   logic [7:0]  paddr, tbl_rd_data, tbl_wr_data, file_rd_data, port_pins, rmw_operand;
   logic [31:0] pwdata, prdata;
   logic [20:0] fetch_addr, ret_addr, tbl_addr;
   logic [15:0] fetch_word;
   logic        tbl_rd_en, tbl_wr_en, rmw_valid, rmw_dest, prescaler_assigned;
   logic        rmw_operand_valid, prescaler_clear;
   logic [11:0] rmw_addr;
   int          errors = 0;
   int          n_compared = 0;
   logic [20:0] wr_seen_addr;
   logic [7:0]  wr_seen_data;
   logic [15:0] prog [0:14] = '{16'h0E10, 16'h0F15, 16'h0BF0, 16'h0904, 16'h0A2C,
      16'h0D11, 16'h0808, 16'h0105, 16'hEE1A, 16'hF0BC, 16'hF123, 16'h0009, 16'h000F,
      16'h0C77, 16'h0E55};
   always #12.5 pclk = ~pclk;
   // the write strobe lasts one clock, so its address and data are caught here
   always @(posedge pclk) begin
      if (tbl_wr_en) begin
         wr_seen_addr <= tbl_addr;
         wr_seen_data <= tbl_wr_data;
      end
   end
   lto_decoder dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fetch_addr(fetch_addr), .fetch_word(fetch_word),
      .ret_addr(ret_addr), .ret_pop(ret_pop), .tbl_addr(tbl_addr), .tbl_rd_en(tbl_rd_en),
      .tbl_rd_data(tbl_rd_data), .tbl_wr_en(tbl_wr_en), .tbl_wr_data(tbl_wr_data),
      .rmw_valid(rmw_valid), .rmw_addr(rmw_addr), .rmw_dest(rmw_dest),
      .file_rd_data(file_rd_data), .port_pins(port_pins),
      .prescaler_assigned(prescaler_assigned), .rmw_operand_valid(rmw_operand_valid),
      .rmw_operand(rmw_operand), .prescaler_clear(prescaler_clear));
   lto_prog_mem pm (.fetch_addr(fetch_addr), .fetch_word(fetch_word), .ret_addr(ret_addr),
      .tbl_addr(tbl_addr), .tbl_rd_data(tbl_rd_data));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // an idle edge first, so a release is never followed by a raise in one step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk("pready", 1, 0);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic        e;
      apb(1'b0, a, 0, d, e);
      chk(what, exp, d);
   endtask
   task automatic t_reset_values;
      logic [31:0] d;
      logic        e;
      rdchk("work", OFS_WORK, 32'h0);
      rdchk("status", OFS_STATUS, 32'h0);
      rdchk("bank", OFS_BANK, 32'h0);
      apb(1'b1, 8'h40, 32'hFF, d, e);
      chk("write err", 1, e);
      apb(1'b0, 8'h40, 0, d, e);
      chk("read err", 1, e);
      chk("read data", 0, d);
   endtask
   task automatic t_program;
      logic [31:0] d;
      logic        e;
      apb(1'b1, OFS_TBLPTR, 32'h100, d, e);
      apb(1'b1, OFS_CTRL, 32'h1, d, e);
      repeat (4 * 24) @(posedge pclk);
      apb(1'b1, OFS_CTRL, 32'h0, d, e);
      rdchk("work", OFS_WORK, 32'h77);
      rdchk("status", OFS_STATUS, 32'h07);
      rdchk("prod", OFS_PROD, 32'h88);
      rdchk("bank", OFS_BANK, 32'h5);
      rdchk("fptr1", OFS_FPTR1, 32'hABC);
      rdchk("tblptr", OFS_TBLPTR, 32'h102);
      rdchk("tbllat", OFS_TBLLAT, 32'h5A);
      rdchk("iptr", OFS_IPTR, 32'h1C);
      chk("table write addr", 32'h102, wr_seen_addr);
      chk("table write data", 32'h5A, wr_seen_data);
      apb(1'b1, OFS_PROD, 32'hFF, d, e);
      rdchk("prod ro", OFS_PROD, 32'h88);
   endtask
   task automatic rmw(input logic [11:0] a, input logic dst, input logic [7:0] op,
                      input logic clr);
      @(posedge pclk);
      rmw_valid <= 1'b1;
      rmw_addr <= a;
      rmw_dest <= dst;
      @(posedge pclk);
      rmw_valid <= 1'b0;
      @(posedge pclk);
      chk("operand valid", 1, rmw_operand_valid);
      chk("operand", op, rmw_operand);
      chk("prescaler clear", clr, prescaler_clear);
   endtask
   task automatic t_rmw;
      rmw(12'h0F1, 1'b1, 8'h3C, 1'b0);
      rmw(12'h0F6, 1'b1, 8'hC3, 1'b1);
      rmw(12'h0F6, 1'b0, 8'hC3, 1'b0);
      prescaler_assigned <= 1'b0;
      rmw(12'h0F6, 1'b1, 8'hC3, 1'b0);
   endtask
   task automatic report_and_stop;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #(25 * 5000);
      errors++;
      report_and_stop();
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {rmw_valid, rmw_dest, rmw_addr} = '0;
      file_rd_data = 8'hC3;
      port_pins = 8'h3C;
      prescaler_assigned = 1'b1;
      for (int i = 0; i < 32; i++) pm.mem[i] = (i < 15) ? prog[i] : 16'h0000;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_values();
      t_program();
      t_rmw();
      report_and_stop();
   end
endmodule
bind lto_decoder lto_decoder_checker #(.PC_W(PC_W), .IO_PORT2_ADDR(IO_PORT2_ADDR),
   .TIMER0_ADDR(TIMER0_ADDR)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .fetch_addr(fetch_addr),
   .ret_addr(ret_addr), .ret_pop(ret_pop), .tbl_rd_en(tbl_rd_en), .tbl_wr_en(tbl_wr_en),
   .rmw_valid(rmw_valid), .rmw_addr(rmw_addr), .rmw_dest(rmw_dest),
   .file_rd_data(file_rd_data), .port_pins(port_pins),
   .prescaler_assigned(prescaler_assigned), .rmw_operand_valid(rmw_operand_valid),
   .rmw_operand(rmw_operand), .prescaler_clear(prescaler_clear));

// >>> tb/lto_prog_mem.sv
`timescale 1ns/1ps
module lto_prog_mem #(
   parameter int              PC_W       = 21,
   parameter int              TP_W       = 21,
   parameter logic [PC_W-1:0] RET_TARGET = PC_W'(20)
) (
   // fetch side
   input  wire logic [PC_W-1:0] fetch_addr,
   output logic [15:0]          fetch_word,
   // return stack and table data
   output logic [PC_W-1:0]      ret_addr,
   input  wire logic [TP_W-1:0] tbl_addr,
   output logic [7:0]           tbl_rd_data
);
   logic [15:0] mem [0:31];
   // space beyond the loaded area reads as no-op so a run-on stays harmless
   assign fetch_word  = (fetch_addr < PC_W'(32)) ? mem[fetch_addr[4:0]] : 16'h0000;
   assign ret_addr    = RET_TARGET;
   // data follows the address so a wrong pointer shows up as wrong data
   assign tbl_rd_data = tbl_addr[7:0] ^ 8'h5A;
endmodule
